// ---- design/msm_slave.sv ----
// Management serial slave: frame engine and two channel register sets
`timescale 1ns/1ps
`default_nettype none
module msm_slave (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mgmt_enable,
	input wire logic mgmt_clock_pin,
	input wire logic mgmt_data_in,
	output logic mgmt_data_out,
	output logic mgmt_data_oe_n,
	input wire logic phy_addr_strap_bit4,
	input wire logic phy_addr_strap_bit3,
	input wire logic phy_addr_strap_bit2,
	input wire logic phy_addr_strap_bit1,
	input wire logic [1:0] loopback_default_strap,
	input wire logic autoneg_default_strap,
	output logic [1:0] loopback_en,
	output logic [1:0] autoneg_en,
	output logic [1:0] autoneg_restart,
	output logic [1:0] dflt_reload
);
	// Pins: mdc, mdio, enable, four address straps, two loopback straps, autoneg strap
	logic [9:0] pin_meta_ff, pin_sync_ff;
	logic mdc_prev_ff;
	logic mdc_s, mdio_s, en_s, an_strap_s, mdc_rise;
	logic [3:0] addr_strap_s;
	logic [1:0] lb_strap_s, settle_ff;
	logic load_dflt;

	msm_pkg::msm_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [5:0] ones_ff, nxt_ones;
	logic [15:0] sh_ff, nxt_sh, tx_ff, nxt_tx, wr_data_ff, nxt_wr_data;
	logic [1:0] op_ff, nxt_op, wr_ff, nxt_wr;
	logic [4:0] reg_ff, nxt_reg, addr_now;
	logic match_ff, nxt_match, ch_ff, nxt_ch, out_ff, nxt_out, oe_n_ff, nxt_oe_n;
	logic [15:0] ctrl_rd [2];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_meta_ff <= 10'h000;
			pin_sync_ff <= 10'h000;
			mdc_prev_ff <= 1'b0;
			settle_ff <= 2'h0;
		end
		else if (ce)
		begin
			pin_meta_ff <= {mgmt_clock_pin, mgmt_data_in, mgmt_enable,
				phy_addr_strap_bit4, phy_addr_strap_bit3, phy_addr_strap_bit2,
				phy_addr_strap_bit1, loopback_default_strap, autoneg_default_strap};
			pin_sync_ff <= pin_meta_ff;
			mdc_prev_ff <= mdc_s;
			// Straps settle through the synchroniser before they are trusted
			if (settle_ff != 2'h3)
			begin
				settle_ff <= settle_ff + 2'h1;
			end
		end
	end

	assign mdc_s = pin_sync_ff[9];
	assign mdio_s = pin_sync_ff[8];
	assign en_s = pin_sync_ff[7];
	assign addr_strap_s = pin_sync_ff[6:3];
	assign lb_strap_s = pin_sync_ff[2:1];
	assign an_strap_s = pin_sync_ff[0];
	assign load_dflt = (settle_ff == msm_pkg::STRAP_SETTLE); // [R2]
	// Only the master's clock times a frame; data is taken on its rising edge
	assign mdc_rise = mdc_s && !mdc_prev_ff; // [R6]
	assign addr_now = {sh_ff[3:0], mdio_s};

	// No mode input is consulted here, so frames are served in every mode [R3]
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_ones = ones_ff;
		nxt_sh = sh_ff;
		nxt_tx = tx_ff;
		nxt_op = op_ff;
		nxt_reg = reg_ff;
		nxt_match = match_ff;
		nxt_ch = ch_ff;
		nxt_out = out_ff;
		nxt_oe_n = oe_n_ff;
		nxt_wr = 2'b00;
		nxt_wr_data = wr_data_ff;
		if (!en_s)
		begin
			nxt_state = msm_pkg::ST_IDLE; // [R1]
			nxt_ones = 6'h00;
			nxt_oe_n = 1'b1; // [R1]
		end
		else if (mdc_rise)
		begin
			nxt_sh = {sh_ff[14:0], mdio_s};
			nxt_cnt = cnt_ff + 4'h1;
			case (state_ff)
				msm_pkg::ST_IDLE:
				begin
					nxt_oe_n = 1'b1;
					if (!mdio_s)
					begin
						nxt_ones = 6'h00;
						// A start without a full preamble is not a frame
						if (ones_ff == msm_pkg::PRE_ONES_MIN) // [R17]
						begin
							nxt_state = msm_pkg::ST_START;
						end
					end
					else if (ones_ff != msm_pkg::PRE_ONES_MIN)
					begin
						nxt_ones = ones_ff + 6'h01;
					end
				end
				msm_pkg::ST_START:
				begin
					nxt_cnt = 4'h0;
					nxt_state = mdio_s ? msm_pkg::ST_OP : msm_pkg::ST_IDLE;
				end
				msm_pkg::ST_OP:
				begin
					if (cnt_ff == msm_pkg::CNT_OP_LAST)
					begin
						nxt_op = {sh_ff[0], mdio_s};
						nxt_cnt = 4'h0;
						nxt_state = (nxt_op == msm_pkg::OP_READ || nxt_op == msm_pkg::OP_WRITE)
							? msm_pkg::ST_PHY : msm_pkg::ST_IDLE;
					end
				end
				msm_pkg::ST_PHY:
				begin
					if (cnt_ff == msm_pkg::CNT_ADDR_LAST)
					begin
						nxt_match = (addr_now[4:1] == addr_strap_s); // [R4]
						nxt_ch = addr_now[0]; // [R5]
						nxt_cnt = 4'h0;
						nxt_state = msm_pkg::ST_REG;
					end
				end
				msm_pkg::ST_REG:
				begin
					if (cnt_ff == msm_pkg::CNT_ADDR_LAST)
					begin
						nxt_reg = addr_now;
						// Only the control layout lives here; other addresses read zero
						nxt_tx = (addr_now == msm_pkg::REG_CTRL) ? ctrl_rd[ch_ff] // [R8] [R9]
							: 16'h0000; // [R18]
						nxt_cnt = 4'h0;
						nxt_state = msm_pkg::ST_TA;
					end
				end
				msm_pkg::ST_TA:
				begin
					if (cnt_ff == msm_pkg::CNT_TA_LAST)
					begin
						nxt_cnt = 4'h0;
						nxt_state = msm_pkg::ST_DATA;
						if (op_ff == msm_pkg::OP_READ && match_ff)
						begin
							nxt_out = tx_ff[15]; // [R7]
							nxt_tx = {tx_ff[14:0], 1'b0};
						end
					end
					else if (op_ff == msm_pkg::OP_READ && match_ff)
					begin
						nxt_out = 1'b0; // [R7]
						nxt_oe_n = 1'b0; // [R7]
					end
				end
				msm_pkg::ST_DATA:
				begin
					if (cnt_ff == msm_pkg::CNT_DATA_LAST)
					begin
						nxt_oe_n = 1'b1;
						nxt_state = msm_pkg::ST_IDLE;
						if (op_ff == msm_pkg::OP_WRITE && match_ff
							&& reg_ff == msm_pkg::REG_CTRL) // [R18]
						begin
							nxt_wr[ch_ff] = 1'b1; // [R5] [R8]
							nxt_wr_data = {sh_ff[14:0], mdio_s};
						end
					end
					else if (!oe_n_ff)
					begin
						nxt_out = tx_ff[15]; // [R7]
						nxt_tx = {tx_ff[14:0], 1'b0};
					end
				end
				default:
				begin
					nxt_state = msm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff <= msm_pkg::ST_IDLE;
			cnt_ff <= 4'h0;
			ones_ff <= 6'h00;
			sh_ff <= 16'h0000;
			tx_ff <= 16'h0000;
			op_ff <= 2'h0;
			reg_ff <= 5'h00;
			match_ff <= 1'b0;
			ch_ff <= 1'b0;
			out_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			wr_ff <= 2'b00;
			wr_data_ff <= 16'h0000;
		end
		else if (ce)
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ones_ff <= nxt_ones;
			sh_ff <= nxt_sh;
			tx_ff <= nxt_tx;
			op_ff <= nxt_op;
			reg_ff <= nxt_reg;
			match_ff <= nxt_match;
			ch_ff <= nxt_ch;
			out_ff <= nxt_out;
			oe_n_ff <= nxt_oe_n;
			wr_ff <= nxt_wr;
			wr_data_ff <= nxt_wr_data;
		end
	end

	assign mgmt_data_out = out_ff;
	assign mgmt_data_oe_n = oe_n_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_ch
			msm_ctrl_reg u_ctrl (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.load_dflt(load_dflt),
				.dflt_loopback(lb_strap_s[gi]),
				.dflt_autoneg(an_strap_s),
				.wr_en(wr_ff[gi]),
				.wr_data(wr_data_ff),
				.rd_data(ctrl_rd[gi]),
				.loopback_en(loopback_en[gi]),
				.autoneg_en(autoneg_en[gi]),
				.autoneg_restart(autoneg_restart[gi]),
				.dflt_reload(dflt_reload[gi])
			); // [R8]
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_disabled_quiet: assert property (!en_s && ce // [R1]
		|=> mgmt_data_oe_n && state_ff == msm_pkg::ST_IDLE)
		else $error("port active while disabled");
	chk_wr_addr_match: assert property (|wr_ff |-> match_ff // [R4]
		&& $past(addr_strap_s) == addr_strap_s)
		else $error("write to foreign address");
	chk_wr_chan_a: assert property (wr_ff[0] |-> !ch_ff && !wr_ff[1]) // [R5]
		else $error("channel A write with address bit set");
	chk_wr_chan_b: assert property (wr_ff[1] |-> ch_ff) // [R5]
		else $error("channel B write with address bit clear");
	chk_wr_ctrl_only: assert property (|wr_ff |-> reg_ff == msm_pkg::REG_CTRL) // [R18]
		else $error("write reached an unimplemented address");
	chk_ta_drive_zero: assert property (state_ff == msm_pkg::ST_TA // [R7]
		&& !mgmt_data_oe_n |-> !mgmt_data_out)
		else $error("turnaround bit not zero");
	chk_read_release: assert property (state_ff == msm_pkg::ST_DATA && ce && mdc_rise // [R7]
		&& en_s && cnt_ff == msm_pkg::CNT_DATA_LAST |=> mgmt_data_oe_n)
		else $error("data line not released after read");
	chk_no_drive_write: assert property (op_ff == msm_pkg::OP_WRITE // [R7]
		&& state_ff == msm_pkg::ST_DATA |-> mgmt_data_oe_n)
		else $error("device drove line during write");
	chk_preamble_need: assert property (state_ff == msm_pkg::ST_IDLE && ce && en_s // [R17]
		&& mdc_rise && ones_ff != msm_pkg::PRE_ONES_MIN |=> state_ff == msm_pkg::ST_IDLE)
		else $error("frame started without preamble");

	cov_write_a: cover property (wr_ff[0]);
	cov_write_b: cover property (wr_ff[1]);
	cov_read_done: cover property (!mgmt_data_oe_n ##1 mgmt_data_oe_n);
	cov_ctrl_reload: cover property (|dflt_reload);
endmodule
`default_nettype wire

// ---- design/msm_pkg.sv ----
// Constants and types for the management serial slave port
// Summary of operation
// R1 - Port used only while management enable high
// R2 - Strap pins set power-up defaults, writes override
// R3 - Port answers in every operating mode
// R4 - Four strap pins give upper address bits
// R5 - Address bit 0 selects channel A or B
// R6 - Master makes the clock; device only samples
// R7 - One shared data line, device drives reads
// R8 - Separate register set for each channel
// R9 - Addresses 0-6 and 15-18 implemented, others not; only address 0 (control) is implemented here
// R10 - Bit 15 reloads defaults, clears next clock
// R11 - Bit 14 loopback, starts from strap
// R12 - Bit 12 autoneg enable, starts from strap
// R13 - Bit 9 writable, writing one restarts autoneg
// R14 - Bit 13 reads zero, bit 6 one
// R15 - Bit 8 one; bits 11,10,7 zero
// R16 - Bits 5 to 0 read-only
// R17 - Master always sends a preamble
// R18 - Unimplemented addresses read zero, ignore writes
package msm_pkg;
	localparam logic [5:0] PRE_ONES_MIN = 6'h20;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [3:0] CNT_OP_LAST = 4'h1;
	localparam logic [3:0] CNT_ADDR_LAST = 4'h4;
	localparam logic [3:0] CNT_TA_LAST = 4'h1;
	localparam logic [3:0] CNT_DATA_LAST = 4'hf;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam int CTRL_RESET_BIT = 15;
	localparam int CTRL_LOOPBACK_BIT = 14;
	localparam int CTRL_AN_EN_BIT = 12;
	localparam int CTRL_AN_RESTART_BIT = 9;
	localparam logic [15:0] CTRL_FIXED_ONES = 16'h0140;
	localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_START = 7'h02,
		ST_OP = 7'h04,
		ST_PHY = 7'h08,
		ST_REG = 7'h10,
		ST_TA = 7'h20,
		ST_DATA = 7'h40
	} msm_state_t;
endpackage

// ---- design/msm_ctrl_reg.sv ----
// Per-channel control register
`timescale 1ns/1ps
`default_nettype none
module msm_ctrl_reg (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic load_dflt,
	input wire logic dflt_loopback,
	input wire logic dflt_autoneg,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] rd_data,
	output logic loopback_en,
	output logic autoneg_en,
	output logic autoneg_restart,
	output logic dflt_reload
);
	logic rst_bit_ff, lb_ff, an_ff, rsa_ff, restart_ff, reload_ff;
	logic nxt_rst_bit, nxt_lb, nxt_an, nxt_rsa, nxt_restart, nxt_reload;

	always_comb
	begin
		nxt_rst_bit = 1'b0;
		nxt_lb = lb_ff;
		nxt_an = an_ff;
		nxt_rsa = rsa_ff;
		nxt_restart = 1'b0;
		nxt_reload = 1'b0;
		// Reload wins over a write landing in the same cycle
		if (rst_bit_ff || load_dflt)
		begin
			nxt_lb = dflt_loopback; // [R2] [R10] [R11]
			nxt_an = dflt_autoneg; // [R2] [R10] [R12]
			nxt_rsa = 1'b0; // [R10]
			nxt_reload = rst_bit_ff; // [R10]
		end
		else if (wr_en)
		begin
			nxt_rst_bit = wr_data[msm_pkg::CTRL_RESET_BIT]; // [R10]
			nxt_lb = wr_data[msm_pkg::CTRL_LOOPBACK_BIT]; // [R11]
			nxt_an = wr_data[msm_pkg::CTRL_AN_EN_BIT]; // [R12]
			nxt_rsa = wr_data[msm_pkg::CTRL_AN_RESTART_BIT]; // [R13]
			nxt_restart = wr_data[msm_pkg::CTRL_AN_RESTART_BIT]; // [R13]
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rst_bit_ff <= msm_pkg::CTRL_RESET_VALUE[msm_pkg::CTRL_RESET_BIT];
			lb_ff <= msm_pkg::CTRL_RESET_VALUE[msm_pkg::CTRL_LOOPBACK_BIT];
			an_ff <= msm_pkg::CTRL_RESET_VALUE[msm_pkg::CTRL_AN_EN_BIT];
			rsa_ff <= msm_pkg::CTRL_RESET_VALUE[msm_pkg::CTRL_AN_RESTART_BIT];
			restart_ff <= 1'b0;
			reload_ff <= 1'b0;
		end
		else if (ce)
		begin
			rst_bit_ff <= nxt_rst_bit;
			lb_ff <= nxt_lb;
			an_ff <= nxt_an;
			rsa_ff <= nxt_rsa;
			restart_ff <= nxt_restart;
			reload_ff <= nxt_reload;
		end
	end

	// Fixed bits are constants, so writes to them have nowhere to land
	assign rd_data = {rst_bit_ff, lb_ff, 1'b0, an_ff, 2'b00, rsa_ff, 9'h000}
		| msm_pkg::CTRL_FIXED_ONES; // [R14] [R15] [R16]
	assign loopback_en = lb_ff;
	assign autoneg_en = an_ff;
	assign autoneg_restart = restart_ff;
	assign dflt_reload = reload_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_reset_self_clear: assert property (rst_bit_ff && ce |=> !rst_bit_ff) // [R10]
		else $error("control reset bit did not clear");
	chk_reset_reload: assert property (rst_bit_ff && ce // [R10]
		|=> lb_ff == $past(dflt_loopback) && an_ff == $past(dflt_autoneg)
		&& !rsa_ff && dflt_reload)
		else $error("reset bit did not reload defaults");
	chk_strap_load: assert property (load_dflt && ce && !rst_bit_ff // [R2]
		|=> lb_ff == $past(dflt_loopback) && an_ff == $past(dflt_autoneg))
		else $error("strap defaults not taken");
	chk_loopback_write: assert property (wr_en && ce && !rst_bit_ff && !load_dflt // [R11]
		|=> loopback_en == $past(wr_data[14]))
		else $error("loopback bit write lost");
	chk_autoneg_write: assert property (wr_en && ce && !rst_bit_ff && !load_dflt // [R12]
		|=> autoneg_en == $past(wr_data[12]))
		else $error("autoneg enable write lost");
	chk_restart_pulse: assert property (wr_en && ce && !rst_bit_ff && !load_dflt // [R13]
		&& wr_data[9] |=> autoneg_restart ##1 (!autoneg_restart || $past(wr_en)))
		else $error("autoneg restart pulse wrong");
	chk_fixed_bits: assert property (rd_data[13] == 1'b0 && rd_data[6] // [R14] [R15]
		&& rd_data[8] && rd_data[11:10] == 2'b00 && !rd_data[7])
		else $error("fixed control bits wrong");
	chk_reserved_bits: assert property (rd_data[5:0] == 6'h00) // [R16]
		else $error("reserved control bits changed");
endmodule
`default_nettype wire

// ---- dv/msm_mgmt_master.sv ----
// Station management master model: makes the management clock and runs frames
`timescale 1ns/1ps
`default_nettype none
module msm_mgmt_master (
	input wire logic clk,
	output logic mdc,
	output logic drv_en,
	output logic drv_val,
	input wire logic mdio_wire,
	output logic [15:0] rd_data,
	output logic rd_done
);
	initial
	begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b0;
		rd_data = 16'h0000;
		rd_done = 1'b0;
	end
	// One bit slot is 8 clk (800 ns); the line is sampled as the clock rises
	task automatic slot(input logic en, input logic v);
		drv_en = en;
		drv_val = v;
		mdc = 1'b0;
		repeat (4) @(negedge clk);
		mdc = 1'b1;
		rd_data = {rd_data[14:0], mdio_wire};
		repeat (4) @(negedge clk);
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, input int pre);
		logic [13:0] hdr;
		hdr = {2'h1, op, phy, ra};
		repeat (pre) slot(1'b1, 1'b1);
		for (int i = 13; i >= 0; i--)
			slot(1'b1, hdr[i]);
		if (op == msm_pkg::OP_READ)
		begin
			// Line released for turnaround and data; pull-up holds it high
			repeat (18) slot(1'b0, 1'b0);
			rd_done = 1'b1;
			@(negedge clk);
			rd_done = 1'b0;
		end
		else
		begin
			slot(1'b1, 1'b1);
			slot(1'b1, 1'b0);
			for (int i = 15; i >= 0; i--)
				slot(1'b1, wd[i]);
		end
		// Clock stands low between frames
		drv_en = 1'b0;
		mdc = 1'b0;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the management serial slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ena = 1'b1;
	logic [1:0] lb_strap = 2'b10;
	logic an_strap = 1'b1;
	logic mdc, drv_en, drv_val, rd_done, d_out, d_oe_n;
	logic [15:0] rd_data, seed, d;
	logic [15:0] n_restart = 16'h0000;
	logic [15:0] n_reload = 16'h0000;
	logic [15:0] exp_restart = 16'h0001;
	logic [1:0] lb_en, an_en, an_rs, reload;
	logic [15:0] exp_q[$];
	int n_errors = 0;
	int tests_run = 0;
	int cyc_cnt = 0;
	wire mdio_wire;
	localparam logic [4:0] PA = 5'h14;
	localparam logic [4:0] PB = 5'h15;
	logic [4:0] ua [8] = '{5'h01, 5'h06, 5'h07, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h1f};
	// Pull-up wins whenever nobody drives the line
	assign mdio_wire = !d_oe_n ? d_out : (drv_en ? drv_val : 1'b1);
	always #50 clk = ~clk;
	msm_mgmt_master i_mst (.clk(clk), .mdc(mdc), .drv_en(drv_en), .drv_val(drv_val),
		.mdio_wire(mdio_wire), .rd_data(rd_data), .rd_done(rd_done));
	msm_slave i_dut (.clk(clk), .rst(rst), .ce(1'b1), .mgmt_enable(ena),
		.mgmt_clock_pin(mdc), .mgmt_data_in(mdio_wire), .mgmt_data_out(d_out),
		.mgmt_data_oe_n(d_oe_n), .phy_addr_strap_bit4(1'b1), .phy_addr_strap_bit3(1'b0),
		.phy_addr_strap_bit2(1'b1), .phy_addr_strap_bit1(1'b0),
		.loopback_default_strap(lb_strap), .autoneg_default_strap(an_strap),
		.loopback_en(lb_en), .autoneg_en(an_en), .autoneg_restart(an_rs),
		.dflt_reload(reload));
	task automatic chk(input logic [15:0] e, input logic [15:0] a);
		tests_run++;
		if (a !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic rd(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e,
		input int pre = 32);
		exp_q.push_back(e);
		i_mst.frame(msm_pkg::OP_READ, p, r, 16'h0000, pre);
	endtask
	task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] v);
		i_mst.frame(msm_pkg::OP_WRITE, p, r, v, 32);
	endtask
	// Result watcher: the oldest note is matched against each finished read
	always @(posedge rd_done)
	begin
		if (exp_q.size() == 0)
			chk(16'h0000, 16'hffff);
		else
			chk(exp_q.pop_front(), rd_data);
	end
	always @(posedge clk)
	begin
		n_restart <= n_restart + 16'(an_rs[0]) + 16'(an_rs[1]);
		n_reload <= n_reload + 16'(reload[0]) + 16'(reload[1]);
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 40000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		seed = 16'h2dd4;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		rd(PA, 5'h00, 16'h1140);
		rd(PB, 5'h00, 16'h5140);
		chk(16'h0002, {14'h0000, lb_en});
		chk(16'h0003, {14'h0000, an_en});
		$display("test defaults done");
		wr(PA, 5'h00, 16'h7fff);
		rd(PA, 5'h00, 16'h5340);
		rd(PB, 5'h00, 16'h5140);
		chk(16'h0003, {14'h0000, lb_en});
		chk(16'h0001, n_restart);
		wr(PA, 5'h00, 16'h0000);
		rd(PA, 5'h00, 16'h0140);
		chk(16'h0002, {14'h0000, an_en});
		$display("test writes done");
		wr(PA, 5'h00, 16'h8000);
		rd(PA, 5'h00, 16'h1140);
		chk(16'h0001, n_reload);
		$display("test reload done");
		// Both edges of each address range, plus the top address
		foreach (ua[i])
		begin
			wr(PA, ua[i], 16'hffff);
			rd(PA, ua[i], 16'h0000);
		end
		rd(PA, 5'h00, 16'h1140);
		$display("test unmapped done");
		wr(5'h02, 5'h00, 16'h4000);
		rd(5'h02, 5'h00, 16'hffff);
		rd(PA, 5'h00, 16'h1140);
		ena = 1'b0;
		repeat (4) @(negedge clk);
		wr(PA, 5'h00, 16'h4000);
		rd(PA, 5'h00, 16'hffff);
		ena = 1'b1;
		repeat (4) @(negedge clk);
		rd(PA, 5'h00, 16'h1140);
		rd(PA, 5'h00, 16'hffff, 20);
		$display("test refusals done");
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			d = seed & 16'h7fff;
			wr(PB, 5'h00, d);
			exp_restart = exp_restart + 16'(d[9]);
			rd(PB, 5'h00, (d & 16'h5200) | 16'h0140);
		end
		chk(exp_restart, n_restart);
		$display("test random done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
